//--- eprom_host.sv
// host controller for a 256K x 16 uv eprom: read, program with verify, identify
// assumes pins pass through level shifters; vpp, vcc and id high voltage are enables
//
// Summary of operation
// - program mode needs raised program supply, select low, gate high together.
// - host drives the full sixteen-bit word on the data lines while programming.
// - fixed pulses per location, verify after each, stop on match or pulse limit.
// - pulse loop at raised core supply; final verify at nominal supplies.
// - select pulse programs one part; a high select inhibits shared parts.
// - verify: gate low, select high, program supply held raised.
// - identify: high voltage on id trigger line, other address lines low but byte select.
// - select does selection and power; gate only enables drivers.
`timescale 1ns/1ps
`include "eprom_host_regs.svh"
module eprom_host #(
  parameter int unsigned T_ACC_NS = `T_ACC_NS,
  parameter int unsigned T_OE_NS = `T_OE_NS,
  parameter int unsigned PULSE_CYCLES = (`T_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int unsigned MAX_PULSES = `MAX_PULSES
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // command
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [`ADDR_W-1:0] cmd_addr,
  input wire logic [`DATA_W-1:0] cmd_wdata,
  output logic cmd_ready,
  // response
  output logic rsp_valid,
  output logic [`DATA_W-1:0] rsp_data,
  output logic rsp_ok,
  output logic [`PULSE_CNT_W-1:0] rsp_pulses,
  // memory pins
  output logic [`ADDR_W-1:0] location_inputs,
  input wire logic [`DATA_W-1:0] word_lines_in,
  output logic [`DATA_W-1:0] word_lines_out,
  output logic word_lines_oe,
  output logic select_pulse_n,
  output logic out_gate_n,
  output logic vpp_raise,
  output logic vcc_raise,
  output logic id_trigger_hv
);
  // ----------------------------------------------------------------
  // wait counts
  // ----------------------------------------------------------------
  localparam int unsigned ACC_GAP_I = (T_ACC_NS - T_OE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int unsigned OE_WAIT_I = (T_OE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
                                      + `SYNC_STAGES + 1;
  localparam int unsigned SETTLE_I = (`T_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam logic [`TMR_W-1:0] ACC_GAP = `TMR_W'(ACC_GAP_I < 1 ? 1 : ACC_GAP_I);
  localparam logic [`TMR_W-1:0] OE_WAIT = `TMR_W'(OE_WAIT_I);
  localparam logic [`TMR_W-1:0] SETTLE = `TMR_W'(SETTLE_I);
  localparam logic [`TMR_W-1:0] PULSE = `TMR_W'(PULSE_CYCLES);
  localparam logic [`PULSE_CNT_W-1:0] PULSE_MAX = `PULSE_CNT_W'(MAX_PULSES);

  eprom_host_pkg::ctl_s q;
  eprom_host_pkg::ctl_s next_q;
  timer_if #(.W(`TMR_W)) tif ();

  wait_timer u_timer (
    .core_clk(core_clk),
    .resetn(resetn),
    .t(tif.tmr)
  );

  // odd parity over an identity byte
  function automatic logic odd_byte(input logic [7:0] b);
    return ^b;
  endfunction : odd_byte

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_q = q;
    tif.load = 1'b0;
    tif.value = '0;
    next_q.rsp_valid = 1'b0;
    // two stage capture of the data lines
    next_q.sync1 = word_lines_in;
    next_q.sync2 = q.sync1;
    case (q.st)
      eprom_host_pkg::S_IDLE: begin
        next_q.ready = 1'b1;
        if (cmd_valid && q.ready) begin
          next_q.ready = 1'b0;
          next_q.op = eprom_host_pkg::op_e'(cmd_op);
          next_q.addr = cmd_addr;
          next_q.wdata = cmd_wdata;
          next_q.pulses = `RST_PULSES;
          next_q.rsp_ok = 1'b0;
          tif.load = 1'b1;
          case (eprom_host_pkg::op_e'(cmd_op))
            eprom_host_pkg::OP_PROGRAM: begin
              next_q.vcc_hi = 1'b1;
              next_q.vpp_en = 1'b1;
              next_q.dq_out = cmd_wdata;
              next_q.dq_oe = 1'b1;
              tif.value = SETTLE;
              next_q.st = eprom_host_pkg::S_SUPPLY;
            end
            eprom_host_pkg::OP_IDENT: begin
              next_q.addr = `RST_ADDR;
              next_q.id_hv = 1'b1;
              tif.value = SETTLE;
              next_q.st = eprom_host_pkg::S_SUPPLY;
            end
            default: begin
              next_q.sel_n = 1'b0;
              tif.value = ACC_GAP;
              next_q.st = eprom_host_pkg::S_ADDR;
            end
          endcase
        end
      end
      eprom_host_pkg::S_SUPPLY: begin
        if (tif.done) begin
          tif.load = 1'b1;
          if (q.op == eprom_host_pkg::OP_PROGRAM && !q.dq_oe) begin
            // device outputs have floated; drive the word again
            next_q.dq_oe = 1'b1;
            tif.value = ACC_GAP;
          end else if (q.op == eprom_host_pkg::OP_PROGRAM) begin
            // low pulse, gate high, this part only
            next_q.sel_n = 1'b0;
            tif.value = PULSE;
            next_q.st = eprom_host_pkg::S_PULSE;
          end else begin
            next_q.sel_n = 1'b0;
            tif.value = ACC_GAP;
            next_q.st = eprom_host_pkg::S_ADDR;
          end
        end
      end
      eprom_host_pkg::S_ADDR: begin
        // gate falls after select and address settle
        if (tif.done) begin
          next_q.gate_n = 1'b0;
          tif.load = 1'b1;
          tif.value = OE_WAIT;
          next_q.st = eprom_host_pkg::S_GATE;
        end
      end
      eprom_host_pkg::S_GATE: begin
        if (tif.done) begin
          next_q.gate_n = 1'b1;
          tif.load = 1'b1;
          if (q.op == eprom_host_pkg::OP_IDENT && !q.addr[`ID_BYTE_POS]) begin
            // maker byte taken, now device byte
            next_q.rdata[7:0] = q.sync2[7:0];
            next_q.addr[`ID_BYTE_POS] = 1'b1;
            tif.value = ACC_GAP;
            next_q.st = eprom_host_pkg::S_ADDR;
          end else if (q.op == eprom_host_pkg::OP_IDENT) begin
            // both bytes checked for odd parity
            next_q.rdata[15:8] = q.sync2[7:0];
            next_q.rsp_ok = odd_byte(q.rdata[7:0]) && odd_byte(q.sync2[7:0]);
            next_q.sel_n = 1'b1;
            next_q.id_hv = 1'b0;
            tif.value = SETTLE;
            next_q.st = eprom_host_pkg::S_RAMPDN;
          end else begin
            next_q.rdata = q.sync2;
            next_q.rsp_ok = (q.op != eprom_host_pkg::OP_VERIFY) || (q.sync2 == q.wdata);
            next_q.sel_n = 1'b1;
            tif.value = 16'h0001;
            next_q.st = eprom_host_pkg::S_RAMPDN;
          end
        end
      end
      eprom_host_pkg::S_PULSE: begin
        if (tif.done) begin
          // verify with select high, gate low, vpp held
          next_q.sel_n = 1'b1;
          next_q.dq_oe = 1'b0;
          next_q.gate_n = 1'b0;
          next_q.pulses = q.pulses + 1'b1;
          tif.load = 1'b1;
          tif.value = OE_WAIT;
          next_q.st = eprom_host_pkg::S_VERIFY;
        end
      end
      eprom_host_pkg::S_VERIFY: begin
        if (tif.done) begin
          next_q.gate_n = 1'b1;
          next_q.rdata = q.sync2;
          tif.load = 1'b1;
          tif.value = SETTLE;
          // stop on match or pulse limit
          if (q.sync2 == q.wdata || q.pulses >= PULSE_MAX) begin
            next_q.rsp_ok = (q.sync2 == q.wdata);
            next_q.vpp_en = 1'b0;
            next_q.vcc_hi = 1'b0;
            next_q.st = eprom_host_pkg::S_RAMPDN;
          end else begin
            next_q.st = eprom_host_pkg::S_SUPPLY;
          end
        end
      end
      eprom_host_pkg::S_RAMPDN: begin
        if (tif.done) begin
          next_q.st = eprom_host_pkg::S_RESP;
        end
      end
      eprom_host_pkg::S_RESP: begin
        next_q.rsp_valid = 1'b1;
        next_q.st = eprom_host_pkg::S_IDLE;
      end
      default: begin
        next_q.st = eprom_host_pkg::S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= '{st: eprom_host_pkg::S_IDLE, op: eprom_host_pkg::OP_READ, ready: 1'b0,
             addr: `RST_ADDR, wdata: `RST_WORD, dq_out: `RST_WORD, dq_oe: 1'b0,
             sel_n: 1'b1, gate_n: 1'b1, vpp_en: 1'b0, vcc_hi: 1'b0, id_hv: 1'b0,
             pulses: `RST_PULSES, sync1: `RST_WORD, sync2: `RST_WORD,
             rdata: `RST_WORD, rsp_valid: 1'b0, rsp_ok: 1'b0};
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign cmd_ready = q.ready;
  assign rsp_valid = q.rsp_valid;
  assign rsp_data = q.rdata;
  assign rsp_ok = q.rsp_ok;
  assign rsp_pulses = q.pulses;
  assign location_inputs = q.addr;
  assign word_lines_out = q.dq_out;
  assign word_lines_oe = q.dq_oe;
  assign select_pulse_n = q.sel_n;
  assign out_gate_n = q.gate_n;
  assign vpp_raise = q.vpp_en;
  assign vcc_raise = q.vcc_hi;
  assign id_trigger_hv = q.id_hv;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  chk_prog_entry_gate: assert property (!q.sel_n && q.vpp_en |-> q.gate_n)
    else $error("program pulse with gate low");
  chk_prog_word_driven: assert property (!q.sel_n && q.vpp_en |->
      q.dq_oe && q.dq_out == q.wdata) else $error("program pulse without the full word driven");
  chk_pulse_limit: assert property (q.pulses <= PULSE_MAX)
    else $error("pulse count above limit");
  chk_pulse_hold: assert property ($fell(q.sel_n) && q.vpp_en |=> !q.sel_n [*8])
    else $error("program pulse too short");
  chk_pulse_core_raised: assert property (!q.sel_n && q.vpp_en |-> q.vcc_hi)
    else $error("program pulse at nominal core supply");
  chk_verify_nominal: assert property (q.op == eprom_host_pkg::OP_VERIFY && !q.gate_n |->
      !q.vcc_hi && !q.vpp_en) else $error("final verify with raised supplies");
  chk_verify_levels: assert property (q.st == eprom_host_pkg::S_VERIFY |->
      q.sel_n && !q.gate_n && q.vpp_en && !q.dq_oe) else $error("program verify levels wrong");
  chk_id_address: assert property (q.id_hv && !q.gate_n |->
      q.addr[`ADDR_W-1:1] == '0 && !q.vpp_en) else $error("identify with address lines high");
  chk_gate_after_select: assert property ($fell(q.gate_n) && !q.vpp_en |->
      !q.sel_n && $stable(q.addr)) else $error("gate lowered without selection");
  chk_no_contention: assert property (q.dq_oe |-> q.gate_n)
    else $error("host drives data while gate low");
  chk_resp_single: assert property (q.rsp_valid |=> !q.rsp_valid && q.ready)
    else $error("response not a single pulse");

  cov_program_retry: cover property (q.st == eprom_host_pkg::S_VERIFY ##1
    q.st == eprom_host_pkg::S_SUPPLY);
  cov_identify_done: cover property (q.rsp_valid && q.op == eprom_host_pkg::OP_IDENT && q.rsp_ok);
  cov_read_done: cover property (q.rsp_valid && q.op == eprom_host_pkg::OP_READ);
  cov_program_fail: cover property (q.rsp_valid && q.op == eprom_host_pkg::OP_PROGRAM &&
    !q.rsp_ok);
endmodule : eprom_host

//--- eprom_host_pkg.sv
// types shared by the eprom host controller and its wait timer
// assumes eprom_host_regs.svh is on the include path
package eprom_host_pkg;
  `include "eprom_host_regs.svh"

  // ----------------------------------------------------------------
  // commands and states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_VERIFY, OP_IDENT} op_e;

  typedef enum logic [3:0] {
    S_IDLE, S_SUPPLY, S_ADDR, S_GATE, S_PULSE, S_VERIFY, S_RAMPDN, S_RESP
  } state_e;

  // ----------------------------------------------------------------
  // state records
  // ----------------------------------------------------------------
  typedef struct packed {
    state_e st;
    op_e op;
    logic ready;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic [`DATA_W-1:0] dq_out;
    logic dq_oe;
    logic sel_n;
    logic gate_n;
    logic vpp_en;
    logic vcc_hi;
    logic id_hv;
    logic [`PULSE_CNT_W-1:0] pulses;
    logic [`DATA_W-1:0] sync1;
    logic [`DATA_W-1:0] sync2;
    logic [`DATA_W-1:0] rdata;
    logic rsp_valid;
    logic rsp_ok;
  } ctl_s;

  typedef struct packed {
    logic [`TMR_W-1:0] count;
  } tmr_s;
endpackage : eprom_host_pkg

//--- eprom_host_regs.svh
// timing counts, widths and idle pin levels for the word eprom host
// assumes a single 250 MHz core clock; every time is in nanoseconds
`ifndef EPROM_HOST_REGS_SVH
`define EPROM_HOST_REGS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADDR_W 18
`define DATA_W 16
`define TMR_W 16
`define PULSE_CNT_W 8
`define ID_BYTE_POS 0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define T_ACC_NS 250
`define T_OE_NS 100
`define T_PULSE_NS 100000
`define T_SETTLE_NS 1000
`define MAX_PULSES 100
`define SYNC_STAGES 2

// ----------------------------------------------------------------
// reset levels of the pins
// ----------------------------------------------------------------
`define RST_ADDR 18'h0_0000
`define RST_WORD 16'h0000
`define RST_PULSES 8'h00
`define RST_TMR 16'h0000

`endif

//--- timer_if.sv
// load and done handshake between the host sequencer and its wait timer
// assumes both ends sit on the same core clock
`timescale 1ns/1ps
interface timer_if #(parameter int W = 16);
  logic load;
  logic [W-1:0] value;
  logic done;

  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface : timer_if

//--- uv_eprom_word_access_tb_top.sv
// self-checking bench for the eprom host: read, program, verify, identify
// assumes the memory model sits on the pins; short pulses and a 3-pulse limit
`timescale 1ns/1ps
`include "eprom_host_regs.svh"
module uv_eprom_word_access_tb_top;
  localparam int unsigned MAXP = 3;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [17:0] cmd_addr = 18'h0_0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [3:0] prog_need = 4'h1;
  logic cmd_ready, rsp_valid, rsp_ok, word_lines_oe, select_pulse_n, out_gate_n;
  logic vpp_raise, vcc_raise, id_trigger_hv, mem_drives;
  logic [15:0] rsp_data, word_lines_in, word_lines_out;
  logic [7:0] rsp_pulses;
  logic [17:0] location_inputs;
  logic [15:0] exp_mem [int];
  int fails = 0;
  int n_compared = 0;

  always #2 core_clk = ~core_clk;

  eprom_host #(.PULSE_CYCLES(20), .MAX_PULSES(MAXP)) DUT (.core_clk(core_clk), .resetn(resetn),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ok(rsp_ok),
    .rsp_pulses(rsp_pulses), .location_inputs(location_inputs), .word_lines_in(word_lines_in),
    .word_lines_out(word_lines_out), .word_lines_oe(word_lines_oe),
    .select_pulse_n(select_pulse_n), .out_gate_n(out_gate_n), .vpp_raise(vpp_raise),
    .vcc_raise(vcc_raise), .id_trigger_hv(id_trigger_hv));

  uv_word_memory u_mem (.location_inputs(location_inputs), .word_lines_out(word_lines_out),
    .word_lines_oe(word_lines_oe), .select_pulse_n(select_pulse_n), .out_gate_n(out_gate_n),
    .vpp_raise(vpp_raise), .id_trigger_hv(id_trigger_hv), .prog_need(prog_need),
    .word_lines_in(word_lines_in), .mem_drives(mem_drives));

  // ----------------------------------------------------------------
  // compare, verdict and command tasks
  // ----------------------------------------------------------------
  task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check_word

  task automatic check_bit(input logic got, input logic exp, input string what);
    check_word({15'h0000, got}, {15'h0000, exp}, what);
  endtask : check_bit

  task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done

  function automatic logic [15:0] stored(input logic [17:0] a);
    return exp_mem.exists(int'(a)) ? exp_mem[int'(a)] : 16'hffff;
  endfunction : stored

  // present one command when ready, then wait for its response pulse
  task automatic run_cmd(input logic [1:0] op, input logic [17:0] a, input logic [15:0] wd,
                         input logic [3:0] need);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= a;
    cmd_wdata <= wd;
    prog_need <= need;
    @(posedge core_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rsp_valid !== 1'b1 && n < 20000);
    if (n >= 20000) check_bit(1'b0, 1'b1, "no response");
  endtask : run_cmd

  task automatic prog_and_check(input logic [17:0] a, input logic [15:0] wd,
                                input logic [3:0] need);
    logic [15:0] now;
    logic fits;
    now = (need <= MAXP) ? (stored(a) & wd) : stored(a);
    fits = (need <= MAXP) && ((stored(a) & wd) == wd);
    run_cmd(2'h1, a, wd, need);
    exp_mem[int'(a)] = now;
    check_word(rsp_data, now, "programmed word");
    check_bit(rsp_ok, fits, "program result");
    check_word({8'h00, rsp_pulses}, fits ? 16'(need) : 16'(MAXP), "pulse count");
  endtask : prog_and_check

  task automatic read_and_check(input logic [1:0] op, input logic [17:0] a, input logic [15:0] wd);
    run_cmd(op, a, wd, 4'h1);
    check_word(rsp_data, stored(a), "word read");
    check_bit(rsp_ok, op == 2'h0 || stored(a) == wd, "read result");
  endtask : read_and_check

  // pins during program pulses, and no fight on the data lines
  always @(negedge core_clk) begin
    if (resetn === 1'b1 && select_pulse_n === 1'b0 && vpp_raise === 1'b1) begin
      check_bit(out_gate_n, 1'b1, "gate during pulse");
      check_bit(word_lines_oe, 1'b1, "word during pulse");
      check_bit(vcc_raise, 1'b1, "core supply during pulse");
    end
    if (word_lines_oe === 1'b1) check_bit(mem_drives, 1'b0, "data line fight");
    if (resetn === 1'b1 && out_gate_n === 1'b0 && vpp_raise === 1'b0) begin
      check_bit(vcc_raise, 1'b0, "core supply in read");
    end
    if (id_trigger_hv === 1'b1 && out_gate_n === 1'b0) begin
      check_word({location_inputs[17:10], location_inputs[8:1]}, 16'h0000, "id address");
    end
  end

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    logic [17:0] a;
    logic [15:0] wd;
    void'($urandom(32'hfb1c_5a96));
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    @(negedge core_clk);
    check_bit(select_pulse_n, 1'b1, "select idle");
    check_bit(out_gate_n, 1'b1, "gate idle");
    check_bit(vpp_raise, 1'b0, "supply idle");
    read_and_check(2'h0, 18'h0_0000, 16'h0000);
    read_and_check(2'h0, 18'h3_ffff, 16'h0000);
    prog_and_check(18'h0_0001, 16'ha5a5, 4'h1);
    prog_and_check(18'h0_0001, 16'h5a5a, 4'h1);
    prog_and_check(18'h3_ffff, 16'h0000, 4'h3);
    prog_and_check(18'h2_0000, 16'h1234, 4'h5);
    read_and_check(2'h2, 18'h0_0001, 16'h0000);
    read_and_check(2'h2, 18'h3_ffff, 16'h0000);
    run_cmd(2'h3, 18'h3_ffff, 16'hffff, 4'h1);
    check_word(rsp_data, {8'h4c, 8'h86}, "id bytes");
    check_bit(rsp_ok, 1'b1, "id parity");
    repeat (6) begin
      a = 18'($urandom);
      wd = 16'($urandom);
      prog_and_check(a, wd, 4'(1 + $urandom % 3));
      read_and_check(2'h0, a, wd);
      read_and_check(2'h2, a, wd);
    end
    test_done();
  end

  initial begin
    #200000;
    fails++;
    $display("ERROR %0t watchdog expired", $time);
    test_done();
  end
endmodule : uv_eprom_word_access_tb_top

//--- uv_word_memory.sv
// behavioural 256K x 16 uv eprom that answers the host controller pins
// assumes data lines have no pull; a released line shows the inverse word
`timescale 1ns/1ps
`include "eprom_host_regs.svh"
module uv_word_memory #(
  parameter int unsigned DLY_NS = 90,
  parameter logic [7:0] MAKER_CODE = 8'h86, // arbitrary value, odd parity
  parameter logic [7:0] PART_CODE = 8'h4c // arbitrary value, odd parity
) (
  // host pins
  input wire logic [`ADDR_W-1:0] location_inputs,
  input wire logic [`DATA_W-1:0] word_lines_out,
  input wire logic word_lines_oe,
  input wire logic select_pulse_n,
  input wire logic out_gate_n,
  input wire logic vpp_raise,
  input wire logic id_trigger_hv,
  // bench control and view
  input wire logic [3:0] prog_need,
  output logic [`DATA_W-1:0] word_lines_in,
  output logic mem_drives
);
  logic [15:0] mem [int];
  logic [15:0] last = 16'hffff;
  logic [15:0] held;
  logic [15:0] val;
  logic [16:0] late;
  logic drv;
  logic armed;
  int pulses_seen;
  int wseq;

  // unwritten words read as all ones
  function automatic logic [15:0] stored(input int a);
    return mem.exists(a) ? mem[a] : 16'hffff;
  endfunction : stored

  // output decode per mode
  always @* begin
    // wseq read here so a write refreshes the word in the same step
    val = (wseq >= 0) ? stored(int'(location_inputs)) : 16'hffff;
    // read with both low, verify with supply up
    drv = (!select_pulse_n && !out_gate_n) || (select_pulse_n && !out_gate_n && vpp_raise);
    // id byte chosen by byte select, lines 17:10 and 8:1 low
    if (id_trigger_hv && location_inputs[17:10] == 8'h00 && location_inputs[8:1] == 8'h00) begin
      val = {8'h00, location_inputs[0] ? PART_CODE : MAKER_CODE};
    end
  end

  // data settles one delay after its latest cause
  assign #(DLY_NS) late = {drv, val};
  assign mem_drives = drv;
  always @* if (late[16] && drv) last = late[15:0];
  assign word_lines_in = word_lines_oe ? word_lines_out : (late[16] && drv) ? late[15:0] : ~last;

  // pulse counts only with supply up, gate high, word driven
  always @(negedge select_pulse_n) begin
    armed = vpp_raise && out_gate_n && word_lines_oe;
    held = word_lines_out;
  end
  // slow cells need several pulses; bits only clear
  always @(posedge select_pulse_n) begin
    if (armed) begin
      pulses_seen++;
      if (pulses_seen >= prog_need) begin
        mem[int'(location_inputs)] = stored(int'(location_inputs)) & held;
        wseq++;
      end
    end
    armed = 1'b0;
  end
  always @(posedge vpp_raise) pulses_seen = 0;
endmodule : uv_word_memory

//--- wait_timer.sv
// down counter that tells the sequencer when a wait has run out
// assumes load values of one or more; done is high while the count is zero
`timescale 1ns/1ps
`include "eprom_host_regs.svh"
module wait_timer (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // sequencer side
  timer_if.tmr t
);
  eprom_host_pkg::tmr_s q;
  eprom_host_pkg::tmr_s next_q;

  // ----------------------------------------------------------------
  // counting
  // ----------------------------------------------------------------
  // load wins over the decrement
  always_comb begin
    next_q = q;
    if (t.load) begin
      next_q.count = t.value;
    end else if (q.count != '0) begin
      next_q.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q.count <= `RST_TMR;
    end else begin
      q <= next_q;
    end
  end

  assign t.done = (q.count == '0);
endmodule : wait_timer
